// File: core/spi_master_slave_port.sv
// spi engine of the synchronous serial port: master and slave roles
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_consts.svh"

// Behaviour
// - port runs only while enable set, owns pins
// - control bits pick role, polarity, phase, rate
// - MSb first; full byte to buffer, flags set
// - next byte may start before buffer read in slave role, or in master role with overwrite enable
// - write during transfer dropped, collision flag set
// - buffer read clears buffer full flag
// - shift register reachable only via buffer
// - master write starts eight-bit transfer immediately
// - receive-only master keeps loading buffer normally
// - idle polarity and output edge selectable
// - master rate: div4, div16, div64, timer, reload
// - edge select gives early data; sample phase
// - slave shifts on external clock, flags last bit
// - slave keeps shifting during sleep
// - daisy chain echoes received bits next burst
// - overwrite enable accepts writes despite unread byte
// - write loads buffer and shift register together
// - mode 0100: slave gated by slave select
// - select high releases data out four clocks later, after pin sync
// - port reset forces bit counter zero
module spi_master_slave_port
(
	input wire logic ref_clk_i, // 250 MHz system clock
	input wire logic nrst_i, // async reset, active low
	input wire logic port_enable_i, // port enable
	input wire logic [3:0] port_mode_i, // role and rate select
	input wire logic clock_idle_polarity_i, // idle level of clock
	input wire logic clock_edge_select_i, // data valid before first edge
	input wire logic sample_phase_select_i, // sample at end of data time
	input wire logic buffer_overwrite_enable_i, // accept writes while full
	input wire logic [7:0] divider_reload_i, // reload for rate divider
	input wire logic rate_timer_tick_i, // rate timer output pulse
	input wire logic sleep_i, // device asleep, master halts
	input wire logic buf_wr_i, // data buffer write strobe
	input wire logic [7:0] buf_wdata_i, // data buffer write data
	input wire logic buf_rd_i, // data buffer read strobe
	input wire logic write_collision_clr_i, // clear collision flag
	input wire logic serial_irq_clr_i, // clear interrupt flag
	output logic [7:0] buf_rdata_o, // data buffer contents
	output logic buffer_full_flag_o, // received byte waiting
	output logic write_collision_flag_o, // write was dropped
	output logic serial_irq_flag_o, // byte complete
	output logic busy_o, // transfer in progress
	input wire logic sck_i, // clock pin level
	output logic sck_o, // clock pin drive value
	output logic sck_oe_o, // clock pin driven
	input wire logic sdi_i, // data in pin
	output logic sdo_o, // data out pin value
	output logic sdo_oe_o, // data out pin driven
	input wire logic ss_n_i // slave select, active low
);
	spi_port_pkg::port_state_s r_r;
	spi_port_pkg::port_state_s r_nxt;
	logic [2:0] pins_s;
	logic sck_s;
	logic sdi_s;
	logic ss_n_s;
	logic is_slave;
	logic ss_mode;
	logic slave_on;
	logic master_on;
	logic rate_tick;
	logic sck_edge;
	logic lead_edge;
	logic trail_edge;
	logic [4:0] first_sample;
	logic master_sample;
	logic master_drive;
	logic in_transfer;

	function automatic logic [9:0] half_period(input logic [3:0] mode, input logic [7:0] reload);
		logic [9:0] h;
		h = `SPI_HALF_DIV4;
		if (mode == spi_port_pkg::MODE_MASTER_DIV16)
			h = `SPI_HALF_DIV16;
		else if (mode == spi_port_pkg::MODE_MASTER_DIV64)
			h = `SPI_HALF_DIV64;
		else if (mode == spi_port_pkg::MODE_MASTER_RELOAD)
			h = {1'b0, reload, 1'b0} + `SPI_HALF_DIV4;
		return h - `SPI_HALF_ONE;
	endfunction

	// clock pin feeds back as the clock input of the slave role only
	spi_pin_sync u_sync
	(
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.pins_i({ss_n_i, sdi_i, sck_i}),
		.rst_val_i(3'h0),
		.pins_o(pins_s)
	);

	assign sck_s = pins_s[0];
	assign sdi_s = pins_s[1];
	assign ss_n_s = pins_s[2];

	always_comb
	begin
		is_slave = (port_mode_i == spi_port_pkg::MODE_SLAVE_SS)
			|| (port_mode_i == spi_port_pkg::MODE_SLAVE_NOSS);
		ss_mode = port_mode_i == spi_port_pkg::MODE_SLAVE_SS;
		slave_on = port_enable_i && is_slave && (!ss_mode || !ss_n_s);
		master_on = port_enable_i && !is_slave;
		in_transfer = r_r.busy || (is_slave && r_r.bit_cnt != 4'h0);
		// master halts while asleep, slave path does not
		rate_tick = 1'b0;
		if (master_on && r_r.busy && !sleep_i)
		begin
			if (port_mode_i == spi_port_pkg::MODE_MASTER_TIMER)
				rate_tick = rate_timer_tick_i;
			else
				rate_tick = r_r.div_cnt == 10'h000;
		end
		sck_edge = sck_s != r_r.sck_prev;
		lead_edge = sck_edge && (sck_s != clock_idle_polarity_i);
		trail_edge = sck_edge && (sck_s == clock_idle_polarity_i);
		first_sample = (clock_edge_select_i ? 5'h00 : `SPI_EDGE_FIRST)
			+ {4'h0, sample_phase_select_i};
		master_sample = (r_r.edge_cnt >= first_sample)
			&& (r_r.edge_cnt[0] == first_sample[0]) && (r_r.bit_cnt < `SPI_BITS);
		if (clock_edge_select_i)
			master_drive = r_r.edge_cnt[0] && (r_r.edge_cnt < `SPI_EDGE_LAST);
		else
			master_drive = !r_r.edge_cnt[0] && (r_r.edge_cnt >= `SPI_EDGE_SECOND)
				&& (r_r.edge_cnt < `SPI_TICK_LAST);
	end

	always_comb
	begin
		r_nxt = r_r;
		r_nxt.sck_prev = sck_s;
		if (write_collision_clr_i)
			r_nxt.write_collision_flag = 1'b0;
		if (serial_irq_clr_i)
			r_nxt.serial_irq_flag = 1'b0;
		if (buf_rd_i)
			r_nxt.buffer_full_flag = 1'b0;
		// buffer write: collision, refusal or load
		if (buf_wr_i && !r_r.write_collision_flag)
		begin
			if (in_transfer)
				r_nxt.write_collision_flag = 1'b1;
			else if (!r_r.buffer_full_flag || buffer_overwrite_enable_i)
			begin
				r_nxt.data_buffer = buf_wdata_i;
				r_nxt.shift_reg = buf_wdata_i;
				r_nxt.sdo_q = buf_wdata_i[7];
				if (master_on)
				begin
					r_nxt.busy = 1'b1;
					r_nxt.edge_cnt = 5'h00;
					r_nxt.bit_cnt = 4'h0;
					r_nxt.sck_q = clock_idle_polarity_i;
					r_nxt.div_cnt = half_period(port_mode_i, divider_reload_i);
				end
			end
		end
		// master engine
		if (master_on && r_r.busy && !sleep_i && port_mode_i != spi_port_pkg::MODE_MASTER_TIMER)
		begin
			if (r_r.div_cnt == 10'h000)
				r_nxt.div_cnt = half_period(port_mode_i, divider_reload_i);
			else
				r_nxt.div_cnt = r_r.div_cnt - 10'h001;
		end
		if (rate_tick)
		begin
			if (r_r.edge_cnt < `SPI_TICK_LAST)
				r_nxt.sck_q = ~r_r.sck_q;
			if (master_drive)
				r_nxt.sdo_q = sample_phase_select_i ? r_r.shift_reg[6] : r_r.shift_reg[7];
			if (master_sample)
			begin
				r_nxt.shift_reg = {r_r.shift_reg[6:0], sdi_s};
				r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
			end
			r_nxt.edge_cnt = r_r.edge_cnt + 5'h01;
			if ((r_nxt.bit_cnt == `SPI_BITS) && (r_r.edge_cnt >= `SPI_EDGE_LAST))
			begin
				r_nxt.data_buffer = r_nxt.shift_reg;
				r_nxt.buffer_full_flag = 1'b1;
				r_nxt.serial_irq_flag = 1'b1;
				r_nxt.busy = 1'b0;
				r_nxt.bit_cnt = 4'h0;
				r_nxt.sck_q = clock_idle_polarity_i;
			end
		end
		// slave engine on synchronised clock, keeps running in sleep
		if (slave_on)
		begin
			if ((clock_edge_select_i && lead_edge) || (!clock_edge_select_i && trail_edge))
			begin
				r_nxt.shift_reg = {r_r.shift_reg[6:0], sdi_s};
				r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
				if (r_r.bit_cnt == `SPI_BITS - 4'h1)
				begin
					r_nxt.data_buffer = {r_r.shift_reg[6:0], sdi_s};
					r_nxt.buffer_full_flag = 1'b1;
					r_nxt.serial_irq_flag = 1'b1;
					r_nxt.bit_cnt = 4'h0;
				end
			end
			else if (sck_edge)
				r_nxt.sdo_q = r_r.shift_reg[7];
		end
		// port reset
		if (!port_enable_i || !r_r.busy && !is_slave)
			r_nxt.sck_q = clock_idle_polarity_i;
		if (!port_enable_i || (ss_mode && ss_n_s))
		begin
			r_nxt.bit_cnt = 4'h0;
			r_nxt.busy = 1'b0;
			r_nxt.edge_cnt = 5'h00;
			r_nxt.sdo_q = r_nxt.shift_reg[7];
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			r_r <= '0;
		else
			r_r <= r_nxt;
	end

	assign buf_rdata_o = r_r.data_buffer;
	assign buffer_full_flag_o = r_r.buffer_full_flag;
	assign write_collision_flag_o = r_r.write_collision_flag;
	assign serial_irq_flag_o = r_r.serial_irq_flag;
	assign busy_o = r_r.busy || (is_slave && r_r.bit_cnt != 4'h0);
	assign sck_o = r_r.sck_q;
	assign sck_oe_o = master_on;
	assign sdo_o = r_r.sdo_q;
	assign sdo_oe_o = master_on || slave_on;
endmodule
`default_nettype wire

// File: core/spi_pin_sync.sv
// three-stage synchroniser for the serial pins with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_consts.svh"

module spi_pin_sync
(
	input wire logic ref_clk_i, // system clock
	input wire logic nrst_i, // async reset, active low
	input wire logic [2:0] pins_i, // raw pin levels
	input wire logic [2:0] rst_val_i, // unused at reset, reserved level view
	output logic [2:0] pins_o // filtered levels
);
	spi_port_pkg::sync_state_s r_r;
	spi_port_pkg::sync_state_s r_nxt;

	// the first stage feeds only the second
	always_comb
	begin
		r_nxt = r_r;
		r_nxt.s1 = pins_i;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		for (int i = 0; i < `SPI_SYNC_STAGES; i++)
		begin
			if (r_r.s2[i] == r_r.s3[i])
				r_nxt.val[i] = r_r.s3[i];
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			r_r <= '0;
		else
			r_r <= r_nxt;
	end

	assign pins_o = r_r.val ^ (rst_val_i & 3'h0);
endmodule
`default_nettype wire

// File: core/spi_port_consts.svh
// timing, width and count constants of the serial port engine
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

`define SPI_BITS 4'h8
`define SPI_HALF_DIV4 10'h002
`define SPI_HALF_DIV16 10'h008
`define SPI_HALF_DIV64 10'h020
`define SPI_HALF_ONE 10'h001
`define SPI_EDGE_LAST 5'h0F
`define SPI_TICK_LAST 5'h10
`define SPI_EDGE_SECOND 5'h02
`define SPI_EDGE_FIRST 5'h01
`define SPI_SYNC_STAGES 3

`endif

// File: core/spi_port_pkg.sv
// types of the serial port engine
package spi_port_pkg;

	typedef enum logic [3:0]
	{
		MODE_MASTER_DIV4 = 4'b0000,
		MODE_MASTER_DIV16 = 4'b0001,
		MODE_MASTER_DIV64 = 4'b0010,
		MODE_MASTER_TIMER = 4'b0011,
		MODE_SLAVE_SS = 4'b0100,
		MODE_SLAVE_NOSS = 4'b0101,
		MODE_MASTER_RELOAD = 4'b1010
	} port_mode_e;

	typedef struct packed
	{
		logic sck_q;
		logic sdo_q;
		logic [7:0] shift_reg;
		logic [7:0] data_buffer;
		logic buffer_full_flag;
		logic write_collision_flag;
		logic serial_irq_flag;
		logic busy;
		logic [4:0] edge_cnt;
		logic [3:0] bit_cnt;
		logic [9:0] div_cnt;
		logic sck_prev;
	} port_state_s;

	typedef struct packed
	{
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] val;
	} sync_state_s;

endpackage

// File: test/spi_far_model.sv
// far side controller: slave to the port, or master when the port is slave
`timescale 1ns/1ps
`default_nettype none
module spi_far_model
(
	input wire logic sck_i, // clock line
	input wire logic sdo_i, // data from port
	output logic sck_o, // clock when master
	output logic ss_n_o, // select when master
	output logic sdi_o // data to port
);
logic [7:0] tx = 8'h00;
logic [7:0] rx = 8'h00;
initial sck_o = 1'b0;
initial ss_n_o = 1'b1;
assign sdi_o = tx[7];
always @(posedge sck_i)
	rx <= {rx[6:0], sdo_i};
always @(negedge sck_i)
	tx <= {tx[6:0], ~tx[7]};
task automatic send(input logic [7:0] b);
	tx = b;
	ss_n_o = 1'b0;
	repeat (8)
	begin
		#24 sck_o = 1'b1;
		#24 sck_o = 1'b0;
	end
	#24 ss_n_o = 1'b1;
endtask
endmodule
`default_nettype wire

// File: test/spi_master_slave_port_tb.sv
// self-checking bench of the serial port engine
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port_tb;
logic ref_clk_i = 1'b0;
logic nrst_i = 1'b0;
logic port_enable_i = 1'b0;
logic [3:0] port_mode_i = 4'h0;
logic buffer_overwrite_enable_i = 1'b0;
logic rate_timer_tick_i = 1'b0;
logic sleep_i = 1'b0;
logic buf_wr_i = 1'b0;
logic buf_rd_i = 1'b0;
logic write_collision_clr_i = 1'b0;
logic serial_irq_clr_i = 1'b0;
logic [7:0] buf_wdata_i = 8'h00;
logic [7:0] divider_reload_i = 8'h01;
logic [7:0] buf_rdata_o;
logic buffer_full_flag_o, write_collision_flag_o, serial_irq_flag_o, busy_o;
logic sck_o, sck_oe_o, sdo_o, sdo_oe_o, far_sck, ss_n_i, sdi_i, sck_i, sdo_line;
int mismatches = 0;
int tests_run = 0;
int n;
assign sck_i = sck_oe_o ? sck_o : far_sck;
assign sdo_line = sdo_oe_o ? sdo_o : ~sdo_o;
always #2 ref_clk_i = ~ref_clk_i;
always @(posedge ref_clk_i)
	rate_timer_tick_i <= #1 ~rate_timer_tick_i;
spi_master_slave_port dut
(
	.ref_clk_i, .nrst_i, .port_enable_i, .port_mode_i, .clock_idle_polarity_i(1'b0),
	.clock_edge_select_i(1'b1), .sample_phase_select_i(1'b0), .buffer_overwrite_enable_i,
	.divider_reload_i, .rate_timer_tick_i, .sleep_i, .buf_wr_i, .buf_wdata_i, .buf_rd_i,
	.write_collision_clr_i, .serial_irq_clr_i, .buf_rdata_o, .buffer_full_flag_o,
	.write_collision_flag_o, .serial_irq_flag_o, .busy_o, .sck_i, .sck_o, .sck_oe_o, .sdi_i,
	.sdo_o, .sdo_oe_o, .ss_n_i
);
spi_far_model far (.sck_i, .sdo_i(sdo_line), .sck_o(far_sck), .ss_n_o(ss_n_i), .sdi_o(sdi_i));
task automatic step();
	@(posedge ref_clk_i);
	#1;
endtask
task automatic compare(input string what, input logic [7:0] seen, input logic [7:0] exp);
	tests_run++;
	if (seen !== exp)
	begin
		mismatches++;
		$display("[FAIL] %s expected %h seen %h", what, exp, seen);
	end
endtask
task automatic strobe(input logic rd, input logic wc, input logic ic);
	{buf_rd_i, write_collision_clr_i, serial_irq_clr_i} = {rd, wc, ic};
	step();
	{buf_rd_i, write_collision_clr_i, serial_irq_clr_i} = 3'b000;
	step();
endtask
task automatic write(input logic [7:0] b);
	buf_wdata_i = b;
	buf_wr_i = 1'b1;
	step();
	buf_wr_i = 1'b0;
endtask
task automatic finish_xfer();
	n = 0;
	while (busy_o !== 1'b0 && n < 2000)
	begin
		step();
		n++;
	end
	step();
endtask
task automatic cfg(input logic [3:0] m);
	port_enable_i = 1'b0;
	step();
	port_mode_i = m;
	port_enable_i = 1'b1;
	step();
endtask
task automatic t_master();
	far.tx = 8'h3C;
	write(8'hA5);
	compare("busy", {7'h00, busy_o}, 8'h01);
	finish_xfer();
	compare("rx", buf_rdata_o, 8'h3C);
	compare("full", {7'h00, buffer_full_flag_o}, 8'h01);
	compare("sent", far.rx, 8'hA5);
endtask
task automatic t_collide();
	strobe(1'b1, 1'b0, 1'b1);
	compare("full", {7'h00, buffer_full_flag_o}, 8'h00);
	far.tx = 8'h96;
	write(8'h11);
	step();
	write(8'h22);
	compare("write_collision_flag", {7'h00, write_collision_flag_o}, 8'h01);
	finish_xfer();
	compare("rx", buf_rdata_o, 8'h96);
	strobe(1'b1, 1'b0, 1'b0);
	write(8'h33);
	compare("busy", {7'h00, busy_o}, 8'h00);
	strobe(1'b0, 1'b1, 1'b0);
	write(8'h44);
	compare("busy", {7'h00, busy_o}, 8'h01);
	finish_xfer();
endtask
task automatic t_rates();
	logic [3:0] md[4] = '{4'h0, 4'h1, 4'h2, 4'hA};
	logic [7:0] q[4] = '{8'h08, 8'h20, 8'h80, 8'h18};
	buffer_overwrite_enable_i = 1'b1;
	divider_reload_i = 8'h02;
	for (int i = 0; i < 4; i++)
	begin
		cfg(md[i]);
		write(8'h5A);
		compare("busy", {7'h00, busy_o}, 8'h01);
		finish_xfer();
		compare("rate", 8'(n >> 2), q[i]);
	end
	cfg(4'h3);
	strobe(1'b0, 1'b0, 1'b1);
	write(8'h5A);
	finish_xfer();
	compare("irq", {7'h00, serial_irq_flag_o}, 8'h01);
endtask
task automatic t_slave();
	buffer_overwrite_enable_i = 1'b0;
	strobe(1'b1, 1'b0, 1'b1);
	cfg(4'h4);
	sleep_i = 1'b1;
	far.send(8'hC3);
	repeat (8) step();
	compare("slave rx", buf_rdata_o, 8'hC3);
	compare("irq", {7'h00, serial_irq_flag_o}, 8'h01);
	strobe(1'b1, 1'b0, 1'b0);
	far.send(8'h0F);
	repeat (8) step();
	compare("echo", far.rx, 8'hC3);
	sleep_i = 1'b0;
endtask
task automatic complete_run();
	$display("comparisons %0d mismatches %0d", tests_run, mismatches);
	if (mismatches == 0 && tests_run > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
initial
begin
	repeat (10) @(posedge ref_clk_i);
	#1 nrst_i = 1'b1;
	step();
	// div16: sdi passes the pin synchroniser, too slow for div4 data
	cfg(4'h1);
	t_master();
	t_collide();
	t_rates();
	t_slave();
	complete_run();
end
initial
begin
	#200000;
	mismatches++;
	complete_run();
end
endmodule
bind spi_master_slave_port spi_port_checker chk (.ref_clk_i, .nrst_i, .port_enable_i,
	.port_mode_i, .clock_idle_polarity_i, .buf_wr_i, .buf_wdata_i, .buf_rd_i, .ss_n_i,
	.buf_rdata_o, .buffer_full_flag_o, .write_collision_flag_o, .serial_irq_flag_o, .busy_o,
	.sck_o, .sck_oe_o, .sdo_oe_o);
`default_nettype wire

// File: test/spi_port_checker.sv
// assertions on the serial port engine ports
`timescale 1ns/1ps
`default_nettype none
module spi_port_checker
(
	input wire logic ref_clk_i, // clock
	input wire logic nrst_i, // reset
	input wire logic port_enable_i, // enable
	input wire logic [3:0] port_mode_i, // mode
	input wire logic clock_idle_polarity_i, // idle
	input wire logic buf_wr_i, // write
	input wire logic [7:0] buf_wdata_i, // data
	input wire logic buf_rd_i, // read
	input wire logic ss_n_i, // select
	input wire logic [7:0] buf_rdata_o, // buffer
	input wire logic buffer_full_flag_o, // full
	input wire logic write_collision_flag_o, // collision
	input wire logic serial_irq_flag_o, // irq
	input wire logic busy_o, // busy
	input wire logic sck_o, // clock
	input wire logic sck_oe_o, // clock drive
	input wire logic sdo_oe_o // data drive
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (!nrst_i);
logic slv;
logic acc;
assign slv = port_mode_i == 4'h4 || port_mode_i == 4'h5;
assign acc = buf_wr_i && port_enable_i && !busy_o && !write_collision_flag_o && !buffer_full_flag_o;
property p_off; !port_enable_i |-> !sck_oe_o && !sdo_oe_o; endproperty
a_off: assert property (p_off) else $error("pins driven while off");
property p_role; sck_oe_o == (port_enable_i && !slv); endproperty
a_role: assert property (p_role) else $error("clock drive wrong");
property p_write_collision_flag; buf_wr_i && busy_o |=> write_collision_flag_o; endproperty
a_write_collision_flag: assert property (p_write_collision_flag) else $error("no collision flag");
property p_load; acc |=> buf_rdata_o == $past(buf_wdata_i); endproperty
a_load: assert property (p_load) else $error("buffer not loaded");
property p_start; acc && !slv |=> busy_o; endproperty
a_start: assert property (p_start) else $error("no transfer start");
property p_rdclr; buf_rd_i && !busy_o |=> !buffer_full_flag_o; endproperty
a_rdclr: assert property (p_rdclr) else $error("full not cleared");
property p_done; $fell(busy_o) && sck_oe_o |-> ##[0:1] (serial_irq_flag_o && buffer_full_flag_o); endproperty
a_done: assert property (p_done) else $error("flags missing");
property p_idle; (sck_oe_o && !busy_o)[*2] |-> sck_o == clock_idle_polarity_i; endproperty
a_idle: assert property (p_idle) else $error("clock not idle");
property p_div4; busy_o && port_mode_i == 4'h0 && $changed(sck_o) |=> $stable(sck_o); endproperty
a_div4: assert property (p_div4) else $error("div4 rate wrong");
property p_ss; (port_mode_i == 4'h4 && ss_n_i)[*8] |-> !sdo_oe_o; endproperty
a_ss: assert property (p_ss) else $error("data out driven");
cover property ($fell(busy_o) && sck_oe_o);
cover property ($rose(serial_irq_flag_o) && !sck_oe_o);
cover property ($rose(write_collision_flag_o));
endmodule
`default_nettype wire
